/* File: can_mailbox_flags.v */
// Functional notes
// - Writing one to a cancel bit requests cancel; zero leaves it; bits 15..1.
// - Cancel before transmit start clears pending and cancel, sets abort-done.
// - Started transmission is not cancelled; on success clear both, set success.
// - Started transmission failing with cancel outstanding clears both, sets abort.
// - Cancel write on non-pending or non-transmit mailbox does nothing.
// - Cancel bit clears itself when its cancellation completes.
// - Bit 0 of pending, cancel, success, abort reads zero, ignores writes.
// - Successful transmission sets that mailbox's success bit.
// - Success bit clears on write of one; zero leaves it.
// - Abort-done bit clears on write of one; zero leaves it.
// - Stored data frame sets data-pending bit if configured; write one clears.
// - Data-pending bits set only by data frames.
// - Data-pending set raises data-received flag unless mailbox masked.
// - Stored remote frame sets remote-pending bit if configured; write one clears.
// - Remote-pending set raises remote-request flag unless mailbox masked.
// - Remote-pending bits set only by remote frames.
// - Mailbox mask blocks receive flags but not pending or unread bits.
// - Mailbox mask blocks empty flag but not transmit bookkeeping.
// - Mailbox mask bits are read/write, one masks, reset to all ones.
// - Clearing a pending bit raises mailbox-empty flag, subject to mask.
// - New message with receive-pending still set sets unread bit; not transmit.
// - Global mask blocks interrupt output but not flag setting.
`timescale 1ns/1ps
`include "can_mbox_flags_map.vh"

module can_mailbox_flags #(
  parameter NUM_MBOX = 16
) (
  input  wire                ref_clk,
  input  wire                rstn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [NUM_MBOX-1:0] eng_tx_start,
  input  wire [NUM_MBOX-1:0] eng_tx_done,
  input  wire [NUM_MBOX-1:0] eng_tx_fail,
  input  wire [NUM_MBOX-1:0] eng_rx_data,
  input  wire [NUM_MBOX-1:0] eng_rx_remote,
  output reg  [NUM_MBOX-1:0] tx_pending,
  output reg                 int_request
);

  localparam [NUM_MBOX-1:0] MB0_OFF = {{(NUM_MBOX-1){1'b1}}, 1'b0};

  reg [NUM_MBOX-1:0] tx_pending_reg;
  reg [NUM_MBOX-1:0] tx_cancel_reg;
  reg [NUM_MBOX-1:0] tx_success_reg;
  reg [NUM_MBOX-1:0] tx_abort_done_reg;
  reg [NUM_MBOX-1:0] rx_data_pending_reg;
  reg [NUM_MBOX-1:0] rx_remote_pending_reg;
  reg [NUM_MBOX-1:0] mailbox_int_mask_reg;
  reg [NUM_MBOX-1:0] unread_message_reg;
  reg [NUM_MBOX-1:0] in_flight_reg;
  reg [3*NUM_MBOX-1:0] mailbox_config_reg;
  reg [3:0]          int_request_flags_reg;
  reg [3:0]          int_global_mask_reg;

  reg [NUM_MBOX-1:0] start_s1;
  reg [NUM_MBOX-1:0] start_s2;
  reg [NUM_MBOX-1:0] done_s1;
  reg [NUM_MBOX-1:0] done_s2;
  reg [NUM_MBOX-1:0] fail_s1;
  reg [NUM_MBOX-1:0] fail_s2;
  reg [NUM_MBOX-1:0] rxd_s1;
  reg [NUM_MBOX-1:0] rxd_s2;
  reg [NUM_MBOX-1:0] rxr_s1;
  reg [NUM_MBOX-1:0] rxr_s2;

  reg [NUM_MBOX-1:0] tx_pending_next;
  reg [NUM_MBOX-1:0] tx_cancel_next;
  reg [NUM_MBOX-1:0] tx_success_next;
  reg [NUM_MBOX-1:0] tx_abort_done_next;
  reg [NUM_MBOX-1:0] rx_data_pending_next;
  reg [NUM_MBOX-1:0] rx_remote_pending_next;
  reg [NUM_MBOX-1:0] unread_message_next;
  reg [NUM_MBOX-1:0] in_flight_next;
  reg [3:0]          int_request_flags_next;

  reg [NUM_MBOX-1:0] cfg_tx;
  reg [NUM_MBOX-1:0] cfg_data;
  reg [NUM_MBOX-1:0] cfg_remote;
  reg [NUM_MBOX-1:0] ok_set;
  reg [NUM_MBOX-1:0] ab_set;
  reg [NUM_MBOX-1:0] rxd_set;
  reg [NUM_MBOX-1:0] rxr_set;
  reg [NUM_MBOX-1:0] ovr_set;
  reg [NUM_MBOX-1:0] cancel_now;
  reg [NUM_MBOX-1:0] pend_clr;
  reg [3:0]          flag_set;
  reg [31:0]         rd_mux;
  reg                addr_ok;
  reg [31:0]         cfg_word;
  reg [3*NUM_MBOX-1:0] config_next;
  integer            i;
  integer            j;

  wire               wr_acc = psel & penable & pwrite & pready;
  wire [NUM_MBOX-1:0] wdat  = pwdata[NUM_MBOX-1:0];

  // Write strobe for one register offset
  function wr_hit;
    input [11:0] ofs;
    begin
      wr_hit = wr_acc & (paddr == ofs);
    end
  endfunction

  // Any bit of a vector
  function any_bit;
    input [NUM_MBOX-1:0] v;
    begin
      any_bit = |v;
    end
  endfunction

  // Two-flop synchronisers for the protocol engine events
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      start_s1 <= {NUM_MBOX{1'b0}};
      start_s2 <= {NUM_MBOX{1'b0}};
      done_s1  <= {NUM_MBOX{1'b0}};
      done_s2  <= {NUM_MBOX{1'b0}};
      fail_s1  <= {NUM_MBOX{1'b0}};
      fail_s2  <= {NUM_MBOX{1'b0}};
      rxd_s1   <= {NUM_MBOX{1'b0}};
      rxd_s2   <= {NUM_MBOX{1'b0}};
      rxr_s1   <= {NUM_MBOX{1'b0}};
      rxr_s2   <= {NUM_MBOX{1'b0}};
    end
    else
    begin
      start_s1 <= eng_tx_start;
      start_s2 <= start_s1;
      done_s1  <= eng_tx_done;
      done_s2  <= done_s1;
      fail_s1  <= eng_tx_fail;
      fail_s2  <= fail_s1;
      rxd_s1   <= eng_rx_data;
      rxd_s2   <= rxd_s1;
      rxr_s1   <= eng_rx_remote;
      rxr_s2   <= rxr_s1;
    end
  end

  // Unpack the per-mailbox configuration field
  always @*
  begin
    cfg_word = 32'h0000_0000;
    for (i = 0; i < NUM_MBOX; i = i + 1)
    begin
      cfg_tx[i]     = mailbox_config_reg[3*i+`CFG_TX_BIT];
      cfg_data[i]   = mailbox_config_reg[3*i+`CFG_DATA_BIT];
      cfg_remote[i] = mailbox_config_reg[3*i+`CFG_REMOTE_BIT];
      if (3*i+2 < 32)
      begin
        cfg_word[3*i +: 3] = mailbox_config_reg[3*i +: 3];
      end
    end
  end

  // Config write image: only fields that fit one data word
  always @*
  begin
    config_next = mailbox_config_reg;
    for (j = 0; j < NUM_MBOX; j = j + 1)
    begin
      if (3*j+2 < 32)
        config_next[3*j +: 3] = pwdata[3*j +: 3];
    end
  end

  // Transmission outcome: done and fail count only for mailboxes actually in flight
  always @*
  begin
    ok_set     = done_s2 & in_flight_reg & tx_pending_reg & MB0_OFF;
    ab_set     = fail_s2 & in_flight_reg & tx_pending_reg & tx_cancel_reg;
    // Cancel of a pending mailbox not yet started completes at once
    cancel_now = tx_cancel_reg & tx_pending_reg & ~in_flight_reg & ~start_s2;
    ab_set     = (ab_set | cancel_now) & MB0_OFF;
    pend_clr   = ok_set | ab_set;
  end

  // Receive events honour the mailbox configuration and frame type
  always @*
  begin
    rxd_set    = rxd_s2 & cfg_data & ~cfg_tx;
    rxr_set    = rxr_s2 & cfg_remote & ~cfg_tx;
    ovr_set    = ((rxd_set | rxr_set) & (rx_data_pending_reg | rx_remote_pending_reg))
                 & ~cfg_tx;
  end

  // Pending: software sets on configured tx boxes, hardware clears
  always @*
  begin
    tx_pending_next = tx_pending_reg;
    if (wr_hit(`OFS_TX_PENDING))
      tx_pending_next = tx_pending_next | (wdat & cfg_tx);
    tx_pending_next = tx_pending_next & ~pend_clr & MB0_OFF;
  end

  // Failed attempt without cancel stays pending and retries
  always @*
  begin
    in_flight_next = (in_flight_reg | (start_s2 & tx_pending_reg)) & ~done_s2 & ~fail_s2;
    in_flight_next = in_flight_next & MB0_OFF;
  end

  // Cancel: write one only to pending tx boxes, self-clears on completion
  always @*
  begin
    tx_cancel_next = tx_cancel_reg;
    if (wr_hit(`OFS_TX_CANCEL))
      tx_cancel_next = tx_cancel_next | (wdat & tx_pending_reg & cfg_tx);
    tx_cancel_next = tx_cancel_next & ~pend_clr & MB0_OFF;
  end

  // Success flags: write one clears, hardware set wins
  always @*
  begin
    tx_success_next = tx_success_reg;
    if (wr_hit(`OFS_TX_SUCCESS))
      tx_success_next = tx_success_next & ~wdat;
    tx_success_next = (tx_success_next | ok_set) & MB0_OFF;
  end

  // Abort flags: write one clears, hardware set wins
  always @*
  begin
    tx_abort_done_next = tx_abort_done_reg;
    if (wr_hit(`OFS_TX_ABORT))
      tx_abort_done_next = tx_abort_done_next & ~wdat;
    tx_abort_done_next = (tx_abort_done_next | ab_set) & MB0_OFF;
  end

  // Data pending flags, unaffected by the mailbox mask
  always @*
  begin
    rx_data_pending_next = rx_data_pending_reg;
    if (wr_hit(`OFS_RX_DATA_PEND))
      rx_data_pending_next = rx_data_pending_next & ~wdat;
    rx_data_pending_next = rx_data_pending_next | rxd_set;
  end

  // Remote pending flags, unaffected by the mailbox mask
  always @*
  begin
    rx_remote_pending_next = rx_remote_pending_reg;
    if (wr_hit(`OFS_RX_REMOTE_PEND))
      rx_remote_pending_next = rx_remote_pending_next & ~wdat;
    rx_remote_pending_next = rx_remote_pending_next | rxr_set;
  end

  // Unread message flags, set on overwrite
  always @*
  begin
    unread_message_next = unread_message_reg;
    if (wr_hit(`OFS_UNREAD_MSG))
      unread_message_next = unread_message_next & ~wdat;
    unread_message_next = unread_message_next | ovr_set;
  end

  // Summary flags gated by the per-mailbox mask
  always @*
  begin
    flag_set[`IF_DATA_RX]    = any_bit(rxd_set & ~mailbox_int_mask_reg);
    flag_set[`IF_REMOTE_RX]  = any_bit(rxr_set & ~mailbox_int_mask_reg);
    flag_set[`IF_MBOX_EMPTY] = any_bit(pend_clr & ~mailbox_int_mask_reg);
    flag_set[`IF_OVERRUN]    = any_bit(ovr_set & ~mailbox_int_mask_reg);
  end

  // Summary flag register: write one clears, set wins
  always @*
  begin
    int_request_flags_next = int_request_flags_reg;
    if (wr_hit(`OFS_INT_FLAGS))
      int_request_flags_next = int_request_flags_next & ~pwdata[3:0];
    int_request_flags_next = int_request_flags_next | flag_set;
  end

  // Flag, configuration and mask registers
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      tx_pending_reg        <= `RST_FLAGS;
      tx_cancel_reg         <= `RST_FLAGS;
      tx_success_reg        <= `RST_FLAGS;
      tx_abort_done_reg     <= `RST_FLAGS;
      rx_data_pending_reg   <= `RST_FLAGS;
      rx_remote_pending_reg <= `RST_FLAGS;
      unread_message_reg    <= `RST_FLAGS;
      in_flight_reg         <= `RST_FLAGS;
      mailbox_int_mask_reg  <= `RST_MBOX_INT_MASK;
      mailbox_config_reg    <= {(3*NUM_MBOX){1'b0}};
      int_request_flags_reg <= 4'h0;
      int_global_mask_reg   <= `RST_INT_GLOBAL_MASK;
    end
    else
    begin
      tx_pending_reg        <= tx_pending_next;
      tx_cancel_reg         <= tx_cancel_next;
      tx_success_reg        <= tx_success_next;
      tx_abort_done_reg     <= tx_abort_done_next;
      rx_data_pending_reg   <= rx_data_pending_next;
      rx_remote_pending_reg <= rx_remote_pending_next;
      unread_message_reg    <= unread_message_next;
      in_flight_reg         <= in_flight_next;
      int_request_flags_reg <= int_request_flags_next;
      if (wr_hit(`OFS_MBOX_INT_MASK))
        mailbox_int_mask_reg <= wdat;
      if (wr_hit(`OFS_MBOX_CONFIG))
        mailbox_config_reg <= config_next;
      if (wr_hit(`OFS_INT_GLOBAL_MASK))
        int_global_mask_reg <= pwdata[3:0];
    end
  end

  // Read multiplexer and address decode
  always @*
  begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `OFS_TX_PENDING:      rd_mux[NUM_MBOX-1:0] = tx_pending_reg;
      `OFS_TX_CANCEL:       rd_mux[NUM_MBOX-1:0] = tx_cancel_reg;
      `OFS_TX_SUCCESS:      rd_mux[NUM_MBOX-1:0] = tx_success_reg;
      `OFS_TX_ABORT:        rd_mux[NUM_MBOX-1:0] = tx_abort_done_reg;
      `OFS_RX_DATA_PEND:    rd_mux[NUM_MBOX-1:0] = rx_data_pending_reg;
      `OFS_RX_REMOTE_PEND:  rd_mux[NUM_MBOX-1:0] = rx_remote_pending_reg;
      `OFS_MBOX_INT_MASK:   rd_mux[NUM_MBOX-1:0] = mailbox_int_mask_reg;
      `OFS_UNREAD_MSG:      rd_mux[NUM_MBOX-1:0] = unread_message_reg;
      `OFS_MBOX_CONFIG:     rd_mux = cfg_word;
      `OFS_INT_FLAGS:       rd_mux[3:0] = int_request_flags_reg;
      `OFS_INT_GLOBAL_MASK: rd_mux[3:0] = int_global_mask_reg;
      default:              addr_ok = 1'b0;
    endcase
  end

  // APB answer: ready in the first cycle of the access phase, registered outputs
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
    end
    else
    begin
      pready      <= psel & ~penable;
      pslverr     <= psel & ~penable & ~addr_ok;
      prdata      <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Registered status outputs toward the rest of the controller
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      tx_pending  <= {NUM_MBOX{1'b0}};
      int_request <= 1'b0;
    end
    else
    begin
      tx_pending  <= tx_pending_next;
      int_request <= |(int_request_flags_next & ~int_global_mask_reg);
    end
  end

endmodule // can_mailbox_flags

/* File: can_mbox_flags_map.vh */
`ifndef CAN_MBOX_FLAGS_MAP_VH
`define CAN_MBOX_FLAGS_MAP_VH
// Byte offsets on the APB register window
`define OFS_TX_PENDING      12'h000
`define OFS_TX_CANCEL       12'h004
`define OFS_TX_SUCCESS      12'h008
`define OFS_TX_ABORT        12'h00c
`define OFS_RX_DATA_PEND    12'h010
`define OFS_RX_REMOTE_PEND  12'h014
`define OFS_MBOX_INT_MASK   12'h018
`define OFS_UNREAD_MSG      12'h01c
`define OFS_MBOX_CONFIG     12'h020
`define OFS_INT_FLAGS       12'h024
`define OFS_INT_GLOBAL_MASK 12'h028
// Reset values
`define RST_FLAGS           16'h0000
`define RST_MBOX_INT_MASK   16'hffff
`define RST_INT_GLOBAL_MASK 4'hf
// Bit positions in the summary interrupt flag and global mask registers
`define IF_DATA_RX          0
`define IF_REMOTE_RX        1
`define IF_MBOX_EMPTY       2
`define IF_OVERRUN          3
// Mailbox config field: [0] transmit box, [1] accepts data, [2] accepts remote
`define CFG_TX_BIT          0
`define CFG_DATA_BIT        1
`define CFG_REMOTE_BIT      2
`endif

/* File: can_flags_checker.sv */
`timescale 1ns/1ps
module can_flags_checker #(
  parameter NUM_MBOX = 16
) (
  input logic                ref_clk,
  input logic                rstn,
  input logic                psel,
  input logic                penable,
  input logic                pwrite,
  input logic [11:0]         paddr,
  input logic [31:0]         pwdata,
  input logic [31:0]         prdata,
  input logic                pready,
  input logic                pslverr,
  input logic [NUM_MBOX-1:0] eng_tx_start,
  input logic [NUM_MBOX-1:0] eng_tx_done,
  input logic [NUM_MBOX-1:0] eng_tx_fail,
  input logic [NUM_MBOX-1:0] eng_rx_data,
  input logic [NUM_MBOX-1:0] eng_rx_remote,
  input logic [NUM_MBOX-1:0] tx_pending,
  input logic                int_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Causes seen at the ports
  wire wr = psel && penable && pready && pwrite;
  wire cw = wr && paddr == 12'h004;
  wire ev = (|eng_tx_done) || (|eng_tx_fail);
  wire rx = (|eng_rx_data) || (|eng_rx_remote);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && paddr > 12'h028 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= 12'h028 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_pend_bit0_zero: assert property (tx_pending[0] == 1'b0)
    else $error("pending bit 0 set");
  a_read_bit0_zero: assert property (pready && !pwrite && paddr <= 12'h00c |-> !prdata[0])
    else $error("transmit flag bit 0 read as one");
  a_pend_fall_cause: assert property (|($past(tx_pending) & ~tx_pending)
    |-> $past(cw) || $past(cw, 2) || $past(ev, 3) || $past(ev, 4))
    else $error("pending cleared without cause");
  a_int_cause: assert property ($rose(int_request) |-> $past(wr) || $past(wr, 2)
    || $past(ev, 3) || $past(ev, 4) || $past(rx, 3) || $past(rx, 4))
    else $error("interrupt raised without cause");
  // Main scenarios reached
  c_cancel: cover property (cw);
  c_int: cover property ($rose(int_request));
  c_err: cover property (pslverr);
endmodule // can_flags_checker

/* File: can_engine_model.sv */
`timescale 1ns/1ps
module can_engine_model (
  input  logic        ref_clk,
  output logic [15:0] eng_tx_start,
  output logic [15:0] eng_tx_done,
  output logic [15:0] eng_tx_fail,
  output logic [15:0] eng_rx_data,
  output logic [15:0] eng_rx_remote
);
  // Event lines idle low between pulses
  initial
  begin
    {eng_tx_start, eng_tx_done, eng_tx_fail, eng_rx_data, eng_rx_remote} = '0;
  end
  // One-cycle event: 0 start, 1 done, 2 fail, 3 data, 4 remote; waits out the sync delay
  task automatic fire(input logic [2:0] kind, input logic [15:0] m);
  begin
    @(posedge ref_clk);
    case (kind)
      3'd0: eng_tx_start <= m;
      3'd1: eng_tx_done <= m;
      3'd2: eng_tx_fail <= m;
      3'd3: eng_rx_data <= m;
      default: eng_rx_remote <= m;
    endcase
    @(posedge ref_clk);
    {eng_tx_start, eng_tx_done, eng_tx_fail, eng_rx_data, eng_rx_remote} <= '0;
    repeat (3) @(posedge ref_clk);
  end
  endtask
endmodule // can_engine_model

/* File: tb.sv */
`timescale 1ns/1ps
`include "can_mbox_flags_map.vh"
module tb;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, int_request, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tx_pending, eng_tx_start, eng_tx_done, eng_tx_fail, eng_rx_data, eng_rx_remote;
  integer      n_errors, n_tests;

  can_mailbox_flags #(.NUM_MBOX(16)) can_mailbox_flags_inst (.ref_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eng_tx_start,
    .eng_tx_done, .eng_tx_fail, .eng_rx_data, .eng_rx_remote, .tx_pending, .int_request);
  can_engine_model can_engine_model_inst (.ref_clk, .eng_tx_start, .eng_tx_done,
    .eng_tx_fail, .eng_rx_data, .eng_rx_remote);

  // Clock, 100 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task stop_test;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (k = 0; pready !== 1'b1; k++)
    begin
      if (k == 20)
      begin
        n_errors++;
        stop_test;
      end
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task t_reset;
    rdchk(`OFS_MBOX_INT_MASK, 32'hffff);
    rdchk(`OFS_TX_CANCEL, 32'h0);
    rdchk(`OFS_TX_SUCCESS, 32'h0);
    rdchk(`OFS_TX_ABORT, 32'h0);
    rdchk(12'h02c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask

  task t_cancel;
    apb(1'b1, `OFS_MBOX_CONFIG, 32'h4448); // Boxes 1,2 transmit; 3 data; 4 remote
    apb(1'b1, `OFS_TX_PENDING, 32'h7);
    rdchk(`OFS_TX_PENDING, 32'h6);
    apb(1'b1, `OFS_TX_CANCEL, 32'h23);
    rdchk(`OFS_TX_CANCEL, 32'h0);
    rdchk(`OFS_TX_PENDING, 32'h4);
    chk({16'h0, tx_pending}, 32'h4);
    rdchk(`OFS_TX_ABORT, 32'h2);
    $display("test cancel done");
  endtask

  task t_started;
    can_engine_model_inst.fire(3'd0, 16'h4);
    apb(1'b1, `OFS_TX_CANCEL, 32'h4);
    rdchk(`OFS_TX_CANCEL, 32'h4);
    apb(1'b1, `OFS_TX_CANCEL, 32'h0);
    rdchk(`OFS_TX_CANCEL, 32'h4);
    can_engine_model_inst.fire(3'd1, 16'h4);
    rdchk(`OFS_TX_PENDING, 32'h0);
    rdchk(`OFS_TX_CANCEL, 32'h0);
    rdchk(`OFS_TX_SUCCESS, 32'h4);
    apb(1'b1, `OFS_TX_SUCCESS, 32'h0);
    rdchk(`OFS_TX_SUCCESS, 32'h4);
    apb(1'b1, `OFS_TX_SUCCESS, 32'h5);
    rdchk(`OFS_TX_SUCCESS, 32'h0);
    $display("test started done");
  endtask

  task t_fail;
    apb(1'b1, `OFS_TX_ABORT, 32'h0);
    rdchk(`OFS_TX_ABORT, 32'h2);
    apb(1'b1, `OFS_TX_ABORT, 32'h3);
    rdchk(`OFS_TX_ABORT, 32'h0);
    apb(1'b1, `OFS_TX_PENDING, 32'h2);
    can_engine_model_inst.fire(3'd0, 16'h2);
    can_engine_model_inst.fire(3'd2, 16'h2);
    rdchk(`OFS_TX_PENDING, 32'h2);
    can_engine_model_inst.fire(3'd0, 16'h2);
    apb(1'b1, `OFS_TX_CANCEL, 32'h2);
    can_engine_model_inst.fire(3'd2, 16'h2);
    rdchk(`OFS_TX_PENDING, 32'h0);
    rdchk(`OFS_TX_ABORT, 32'h2);
    rdchk(`OFS_TX_CANCEL, 32'h0);
    rdchk(`OFS_INT_FLAGS, 32'h0);
    $display("test fail done");
  endtask

  task t_rx;
    apb(1'b1, `OFS_MBOX_INT_MASK, 32'hffe7);
    apb(1'b1, `OFS_INT_GLOBAL_MASK, 32'he);
    can_engine_model_inst.fire(3'd3, 16'h18);
    rdchk(`OFS_RX_DATA_PEND, 32'h8);
    rdchk(`OFS_RX_REMOTE_PEND, 32'h0);
    chk({31'h0, int_request}, 32'h1);
    can_engine_model_inst.fire(3'd4, 16'h18);
    rdchk(`OFS_RX_REMOTE_PEND, 32'h10);
    rdchk(`OFS_RX_DATA_PEND, 32'h8);
    rdchk(`OFS_INT_FLAGS, 32'h3);
    can_engine_model_inst.fire(3'd3, 16'h8);
    rdchk(`OFS_UNREAD_MSG, 32'h8);
    apb(1'b1, `OFS_RX_DATA_PEND, 32'h8);
    rdchk(`OFS_RX_DATA_PEND, 32'h0);
    apb(1'b1, `OFS_INT_FLAGS, 32'hf);
    $display("test receive done");
  endtask

  task t_empty;
    apb(1'b1, `OFS_MBOX_INT_MASK, 32'hfffd);
    apb(1'b1, `OFS_INT_GLOBAL_MASK, 32'hb);
    apb(1'b1, `OFS_TX_PENDING, 32'h2);
    apb(1'b1, `OFS_TX_CANCEL, 32'h2);
    rdchk(`OFS_INT_FLAGS, 32'h4);
    chk({31'h0, int_request}, 32'h1);
    $display("test empty done");
  endtask

  // Reset for 3 cycles, then the scenarios
  initial
  begin
    n_errors = 0; n_tests = 0; rstn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_cancel;
    t_started;
    t_fail;
    t_rx;
    t_empty;
    stop_test;
  end
endmodule // tb

bind can_mailbox_flags can_flags_checker #(.NUM_MBOX(NUM_MBOX)) can_flags_checker_inst (
  .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .eng_tx_start, .eng_tx_done, .eng_tx_fail, .eng_rx_data, .eng_rx_remote, .tx_pending,
  .int_request);
